/* File: shared/acs_pkg.sv */
package acs_pkg;
    // APB address width in bits
    localparam int ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL0 = 12'h097;
    localparam logic [11:0] IDX_CLKDIV = 12'h098;
    localparam logic [11:0] IDX_CHSEL = 12'h099;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h09A;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h09B;
    localparam logic [11:0] IDX_STATE = 12'h09C;

    localparam logic [11:0] ADDR_CTRL0 = IDX_CTRL0 << 2;
    localparam logic [11:0] ADDR_CLKDIV = IDX_CLKDIV << 2;
    localparam logic [11:0] ADDR_CHSEL = IDX_CHSEL << 2;
    localparam logic [11:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
    localparam logic [11:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;
    localparam logic [11:0] ADDR_STATE = IDX_STATE << 2;

    // converter_control_zero field positions
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_ENABLE = 2;
    localparam int BIT_DONE = 3;
    localparam int BIT_EDGE = 4;
    localparam int BIT_TIMER = 5;
    localparam int BIT_COMP_IE = 6;
    localparam int BIT_BND_IE = 7;

    // Start modes
    localparam logic [1:0] MODE_TIMER_STOP = 2'h0;
    localparam logic [1:0] MODE_IMMEDIATE = 2'h1;
    localparam logic [1:0] MODE_EDGE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // Event status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_BOUNDARY = 1;
    localparam int IRQ_IGNORED = 2;
    localparam int IRQ_W = 3;

    localparam int NUM_CH = 8;
    localparam int DIV_W = 3;

    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [2:0] RST_CLKDIV = 3'h0;
    localparam logic [7:0] RST_CHSEL = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;

    // Converter clock window that software must respect
    localparam int CORE_CLK_HZ = 100000000;
    localparam int CONV_CLK_MIN_HZ = 320000;
    localparam int CONV_CLK_MAX_HZ = 9000000;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b01,
        ACS_BUSY = 2'b10
    } acs_state_t;
endpackage

/* File: verilog/acs_clkdiv.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_clkdiv
    import acs_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic reset_n, // Async reset
    input wire logic run, // Divider enable
    input wire logic [DIV_W-1:0] div_code, // Divide by code plus one
    output logic tick // Converter clock enable pulse
);
    logic [DIV_W-1:0] count_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (count_r >= div_code) begin // [RL1]
            count_r <= '0;
            tick <= 1'b1;
        end else begin
            count_r <= count_r + 3'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/acs_top.sv */
// What this block does
// [RL1] The converter clock enable is the core clock divided by a chosen ratio of one to eight.
// [RL2] Software picks a ratio that keeps the converter clock inside its allowed frequency window; the divider gives 12.5 MHz or more, over the 9 MHz limit.
// [RL3] A pin's digital input is cut off while its channel is selected and the converter is on.
// [RL4] A pin is reduced-tolerance only when selected, converter on and chip not powered down.
// [RL5] In idle the converter keeps running and a completion interrupt raises a wake-up.
// [RL6] No conversion runs in power-down or total power-down.
// [RL7] Start mode 00 starts on each timer-0 overflow when the timer bit is set, else stops.
// [RL8] Start mode 01 starts a conversion right after the field is written.
// [RL9] Start mode 10 starts a conversion on the chosen edge of the external trigger pin.
// [RL10] The edge bit picks falling edge when zero and rising edge when one.
// [RL11] The enable bit powers the converter; clear, the converter stays powered down.
// [RL12] The done flag is set at every finished conversion and only a written zero clears it.
// [RL13] Done flag with its enable and the global enable requests an interrupt.
// [RL14] Boundary flag with its enable and the global enable requests an interrupt.
// [RL15] Timer and edge triggers are ignored while a conversion is in progress.
// [RL16] Clearing the start mode, and the timer bit, stops further conversions.
// [RL17] Start mode 11 acts as stop mode.
`timescale 1ns/1ns
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input wire logic ref_clk, // Core clock, 100 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic timer0_overflow, // Timer 0 overflow pulse
    input wire logic external_trigger_pin, // External start pin level
    input wire logic conv_done, // Conversion or set finished pulse
    input wire logic boundary_flag, // Boundary flag level
    input wire logic global_irq_enable, // Converter global interrupt enable
    input wire logic idle_mode, // Chip is idle
    input wire logic power_down, // Chip in power-down
    input wire logic total_power_down, // Chip in total power-down
    output logic conv_start, // Start conversion pulse
    output logic conv_abort, // Abort conversion pulse
    output logic conv_clk_en, // Converter clock enable pulse
    output logic converter_powered, // Converter analog power on
    output logic [NUM_CH-1:0] digital_input_disable, // Per-pin input cut-off
    output logic [NUM_CH-1:0] low_tolerance, // Per-pin reduced tolerance
    output logic adc_irq_req, // Completion or boundary interrupt
    output logic idle_wakeup, // Wake from idle
    output logic irq // Masked event interrupt
);
    logic [7:0] ctrl_r;
    logic [DIV_W-1:0] clkdiv_r;
    logic [NUM_CH-1:0] chsel_r;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_status_nxt;
    logic [31:0] rd_nxt;
    logic done_nxt;
    logic imm_pend_r;
    logic pin_prev_r;
    logic pin_primed_r;
    logic bnd_prev_r;
    acs_state_t state_r;

    logic addr_hit;
    logic apb_wr;
    logic wr_ctrl;
    logic [1:0] mode;
    logic enabled;
    logic powered_down;
    logic can_run;
    logic stop_mode;
    logic pin_rise;
    logic pin_fall;
    logic trig_timer;
    logic trig_edge;
    logic trig_any;
    logic start_cond;
    logic stop_cond;

    // Bus decode; zero wait states so every access ends in its first access cycle
    always_comb begin
        unique case (paddr)
            ADDR_CTRL0, ADDR_CLKDIV, ADDR_CHSEL,
            ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_STATE: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign apb_wr = psel & penable & pwrite & addr_hit;
    assign wr_ctrl = apb_wr & (paddr == ADDR_CTRL0);

    always_comb begin
        rd_nxt = 32'h0;
        unique case (paddr)
            ADDR_CTRL0: rd_nxt[7:0] = ctrl_r;
            ADDR_CLKDIV: rd_nxt[DIV_W-1:0] = clkdiv_r;
            ADDR_CHSEL: rd_nxt[NUM_CH-1:0] = chsel_r;
            ADDR_IRQ_STATUS: rd_nxt[IRQ_W-1:0] = irq_status_r;
            ADDR_IRQ_MASK: rd_nxt[IRQ_W-1:0] = irq_mask_r;
            ADDR_STATE: rd_nxt[0] = (state_r == ACS_BUSY);
            default: rd_nxt = 32'h0;
        endcase
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // Completion flag: hardware set beats a software clear in the same cycle
    assign done_nxt = conv_done | (ctrl_r[BIT_DONE] & ~(wr_ctrl & ~pwdata[BIT_DONE])); // [RL12]

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= RST_CTRL0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= pwdata[7:0];
            end
            ctrl_r[BIT_DONE] <= done_nxt; // [RL12]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkdiv_r <= RST_CLKDIV;
            chsel_r <= RST_CHSEL;
            irq_mask_r <= RST_IRQ;
        end else if (apb_wr) begin
            if (paddr == ADDR_CLKDIV) begin
                clkdiv_r <= pwdata[DIV_W-1:0];
            end
            if (paddr == ADDR_CHSEL) begin
                chsel_r <= pwdata[NUM_CH-1:0];
            end
            if (paddr == ADDR_IRQ_MASK) begin
                irq_mask_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Immediate start is armed by the write itself, not by the mode staying 01
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            imm_pend_r <= 1'b0;
        end else begin
            imm_pend_r <= wr_ctrl && (pwdata[1:0] == MODE_IMMEDIATE); // [RL8]
        end
    end

    assign mode = ctrl_r[BIT_MODE_HI:BIT_MODE_LO];
    assign enabled = ctrl_r[BIT_ENABLE];
    assign powered_down = power_down | total_power_down;
    assign can_run = enabled & ~powered_down; // [RL6] [RL11]
    assign stop_mode = ((mode == MODE_TIMER_STOP) & ~ctrl_r[BIT_TIMER])
        | (mode == MODE_RESERVED); // [RL16] [RL17]

    // Edge detector; primed flag avoids a false edge from the reset value
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev_r <= 1'b0;
            pin_primed_r <= 1'b0;
            bnd_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= external_trigger_pin;
            pin_primed_r <= 1'b1;
            bnd_prev_r <= boundary_flag;
        end
    end

    assign pin_rise = pin_primed_r & external_trigger_pin & ~pin_prev_r;
    assign pin_fall = pin_primed_r & ~external_trigger_pin & pin_prev_r;
    assign trig_timer = (mode == MODE_TIMER_STOP) & ctrl_r[BIT_TIMER] & timer0_overflow; // [RL7]
    assign trig_edge = (mode == MODE_EDGE)
        & (ctrl_r[BIT_EDGE] ? pin_rise : pin_fall); // [RL9] [RL10]
    assign trig_any = trig_timer | trig_edge;
    assign start_cond = (state_r == ACS_IDLE) & can_run
        & (trig_any | (imm_pend_r & (mode == MODE_IMMEDIATE))); // [RL15]
    assign stop_cond = stop_mode | ~can_run; // [RL16]

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ACS_IDLE;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
        end else begin
            conv_start <= start_cond;
            conv_abort <= 1'b0;
            unique case (state_r)
                ACS_IDLE: begin
                    if (start_cond) begin
                        state_r <= ACS_BUSY;
                    end
                end
                ACS_BUSY: begin
                    if (conv_done) begin
                        state_r <= ACS_IDLE;
                    end else if (stop_cond) begin
                        state_r <= ACS_IDLE; // [RL16] [RL6]
                        conv_abort <= 1'b1;
                    end
                end
            endcase
        end
    end

    acs_clkdiv u_clkdiv (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(can_run),
        .div_code(clkdiv_r),
        .tick(conv_clk_en)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_pin
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    digital_input_disable[gi] <= 1'b0;
                    low_tolerance[gi] <= 1'b0;
                end else begin
                    digital_input_disable[gi] <= chsel_r[gi] & enabled; // [RL3]
                    low_tolerance[gi] <= chsel_r[gi] & can_run; // [RL4]
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_powered <= 1'b0;
            adc_irq_req <= 1'b0;
            idle_wakeup <= 1'b0;
        end else begin
            converter_powered <= can_run; // [RL11]
            adc_irq_req <= global_irq_enable
                & ((ctrl_r[BIT_DONE] & ctrl_r[BIT_COMP_IE]) // [RL13]
                | (boundary_flag & ctrl_r[BIT_BND_IE])); // [RL14]
            idle_wakeup <= idle_mode & global_irq_enable
                & ctrl_r[BIT_DONE] & ctrl_r[BIT_COMP_IE]; // [RL5]
        end
    end

    // Event status, write one to clear; a new event wins over the clear
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (apb_wr && (paddr == ADDR_IRQ_STATUS)) begin
            irq_status_nxt = irq_status_r & ~pwdata[IRQ_W-1:0];
        end
        if (conv_done) begin
            irq_status_nxt[IRQ_DONE] = 1'b1;
        end
        if (boundary_flag && !bnd_prev_r) begin
            irq_status_nxt[IRQ_BOUNDARY] = 1'b1;
        end
        if ((state_r == ACS_BUSY) && trig_any) begin
            irq_status_nxt[IRQ_IGNORED] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_r <= RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    sequence s_imm_write;
        wr_ctrl && (pwdata[1:0] == MODE_IMMEDIATE) && pwdata[BIT_ENABLE];
    endsequence

    sequence s_imm_ready;
        (state_r == ACS_IDLE) && !powered_down && (mode == MODE_IMMEDIATE);
    endsequence

    a_imm_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL8]
        s_imm_write ##1 s_imm_ready |=> conv_start)
        else $error("immediate start did not begin a conversion");

    a_timer_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL7]
        (state_r == ACS_IDLE) && can_run && (mode == MODE_TIMER_STOP)
        && ctrl_r[BIT_TIMER] && timer0_overflow |=> conv_start)
        else $error("timer overflow did not start a conversion");

    a_edge_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL10]
        (state_r == ACS_IDLE) && can_run && (mode == MODE_EDGE) && pin_primed_r
        && ctrl_r[BIT_EDGE] && $rose(external_trigger_pin) |=> conv_start)
        else $error("rising edge did not start a conversion");

    a_busy_ignores: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL15]
        (state_r == ACS_BUSY) |=> !conv_start)
        else $error("trigger accepted during a conversion");

    a_stop_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL17]
        conv_start |-> $past(!stop_mode && can_run))
        else $error("conversion started in stop mode or powered down");

    a_done_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL12]
        conv_done || (ctrl_r[BIT_DONE] && !(wr_ctrl && !pwdata[BIT_DONE]))
        |=> ctrl_r[BIT_DONE])
        else $error("done flag lost");

    a_comp_irq: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL13]
        ctrl_r[BIT_DONE] && ctrl_r[BIT_COMP_IE] && global_irq_enable |=> adc_irq_req)
        else $error("completion interrupt missing");

    a_bnd_irq: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL14]
        adc_irq_req |-> $past(global_irq_enable && ((ctrl_r[BIT_DONE] && ctrl_r[BIT_COMP_IE])
        || (boundary_flag && ctrl_r[BIT_BND_IE]))))
        else $error("interrupt without an enabled cause");

    a_pin_cutoff: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL4]
        low_tolerance[0] |-> digital_input_disable[0] && $past(!powered_down && chsel_r[0]))
        else $error("reduced tolerance without its conditions");

    a_idle_wake: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL5]
        idle_mode && conv_done
        ##1 idle_mode && ctrl_r[BIT_COMP_IE] && global_irq_enable |=> idle_wakeup)
        else $error("no wake-up from idle on completion");
endmodule
`default_nettype wire

/* File: verif/acs_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_conv_model (
    input wire logic ref_clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic conv_start, // Begin request
    input wire logic conv_abort, // Stop request
    input wire logic [7:0] conv_delay, // Cycles until finished, at least 1
    output logic conv_done // Finished pulse
);
    logic [7:0] cnt_r;

    // Abort drops the pending result, so no stale done pulse follows a stop unless the count is already at one when the abort arrives
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 8'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_r == 8'h01);
            if (conv_start) begin
                cnt_r <= conv_delay;
            end else if (conv_abort) begin
                cnt_r <= 8'h00;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench
    import acs_pkg::*;
;
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic tmr, pin, done, bnd, gie, idle, pd, tpd, start, abort, clk_en, pwr;
    logic adc_irq, wake, irq, e;
    logic [7:0] dis, lowtol, dly;
    int n_mismatch, num_checks, n_start, n_abort, n0, p;

    acs_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_overflow(tmr), .external_trigger_pin(pin),
        .conv_done(done), .boundary_flag(bnd), .global_irq_enable(gie), .idle_mode(idle),
        .power_down(pd), .total_power_down(tpd), .conv_start(start), .conv_abort(abort),
        .conv_clk_en(clk_en), .converter_powered(pwr), .digital_input_disable(dis),
        .low_tolerance(lowtol), .adc_irq_req(adc_irq), .idle_wakeup(wake), .irq(irq));
    acs_conv_model i_conv (.ref_clk(ref_clk), .reset_n(reset_n), .conv_start(start),
        .conv_abort(abort), .conv_delay(dly), .conv_done(done));

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (start === 1'b1) n_start++;
        if (abort === 1'b1) n_abort++;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, x, q)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pulse_timer();
        @(posedge ref_clk);
        tmr <= 1'b1;
        @(posedge ref_clk);
        tmr <= 1'b0;
        tick(3);
    endtask
    task automatic set_pin(input logic v);
        @(posedge ref_clk);
        pin <= v;
        tick(4);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial begin
        ref_clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        tmr = 0; pin = 1; bnd = 0; gie = 1; idle = 0; pd = 0; tpd = 0; dly = 8'h05;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd("ctrl0 reset", ADDR_CTRL0, 32'h0000_0000);
        rd("clkdiv reset", ADDR_CLKDIV, 32'h0000_0000);
        rd("status reset", ADDR_IRQ_STATUS, 32'h0000_0000);
        `CHK("powered", 1'b0, pwr)
        apb(1'b0, 12'h25D, 32'h0000_0000);
        `CHK("unaligned err", 1'b1, e)
        // Mode 11 keeps the divider running without starting anything
        wr(ADDR_CTRL0, 32'h0000_0007);
        // Ratio eight ends the sweep: the slowest rate this core clock gives
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_CLKDIV, k);
            tick(12);
            p = 0;
            do @(posedge ref_clk); while (clk_en !== 1'b1);
            do begin @(posedge ref_clk); p++; end while (clk_en !== 1'b1 && p < 20);
            `CHK("div period", k + 1, p)
        end
        `CHK("stop starts", 0, n_start)
        wr(ADDR_CHSEL, 32'h0000_00A5);
        tick(2);
        `CHK("dis", 8'hA5, dis)
        `CHK("lowtol", 8'hA5, lowtol)
        `CHK("powered on", 1'b1, pwr)
        pd <= 1'b1;
        tick(3);
        `CHK("lowtol pd", 8'h00, lowtol)
        `CHK("powered pd", 1'b0, pwr)
        pd <= 1'b0;
        tpd <= 1'b1;
        tick(3);
        `CHK("lowtol tpd", 8'h00, lowtol)
        tpd <= 1'b0;
        wr(ADDR_CTRL0, 32'h0000_0000);
        tick(2);
        `CHK("dis off", 8'h00, dis)
        `CHK("powered off", 1'b0, pwr)
        idle <= 1'b1;
        n0 = n_start;
        wr(ADDR_CTRL0, 32'h0000_0045);
        tick(4);
        `CHK("imm start", n0 + 1, n_start)
        tick(8);
        rd("done set", ADDR_CTRL0, 32'h0000_004D);
        `CHK("comp irq", 1'b1, adc_irq)
        `CHK("wake", 1'b1, wake)
        gie <= 1'b0;
        tick(2);
        `CHK("comp irq gie", 1'b0, adc_irq)
        `CHK("wake gie", 1'b0, wake)
        gie <= 1'b1;
        wr(ADDR_CTRL0, 32'h0000_004C);
        rd("done kept", ADDR_CTRL0, 32'h0000_004C);
        wr(ADDR_CTRL0, 32'h0000_0044);
        rd("done clr", ADDR_CTRL0, 32'h0000_0044);
        tick(2);
        `CHK("comp irq clr", 1'b0, adc_irq)
        idle <= 1'b0;
        // Long conversion so that a second trigger lands while busy
        dly <= 8'h28;
        wr(ADDR_CTRL0, 32'h0000_0024);
        n0 = n_start;
        pulse_timer();
        `CHK("timer start", n0 + 1, n_start)
        pulse_timer();
        `CHK("busy ignore", n0 + 1, n_start)
        rd("busy state", ADDR_STATE, 32'h0000_0001);
        rd("ignored evt", ADDR_IRQ_STATUS, 32'h0000_0005);
        wr(ADDR_CTRL0, 32'h0000_0004);
        tick(3);
        `CHK("abort", 1, n_abort)
        rd("idle state", ADDR_STATE, 32'h0000_0000);
        pulse_timer();
        `CHK("timer off", n0 + 1, n_start)
        wr(ADDR_CTRL0, 32'h0000_0027);
        pulse_timer();
        `CHK("mode 11", n0 + 1, n_start)
        dly <= 8'h03;
        wr(ADDR_CTRL0, 32'h0000_0024);
        pulse_timer();
        tick(6);
        pulse_timer();
        `CHK("rearm", n0 + 3, n_start)
        wr(ADDR_CTRL0, 32'h0000_0006);
        set_pin(1'b0);
        `CHK("fall start", n0 + 4, n_start)
        tick(6);
        set_pin(1'b1);
        `CHK("rise ignored", n0 + 4, n_start)
        wr(ADDR_CTRL0, 32'h0000_0016);
        set_pin(1'b0);
        `CHK("fall ignored", n0 + 4, n_start)
        set_pin(1'b1);
        `CHK("rise start", n0 + 5, n_start)
        tick(6);
        wr(ADDR_CTRL0, 32'h0000_0084);
        wr(ADDR_IRQ_STATUS, 32'h0000_0007);
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        bnd <= 1'b1;
        tick(3);
        `CHK("bnd irq", 1'b1, adc_irq)
        `CHK("irq on", 1'b1, irq)
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        tick(2);
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        tick(2);
        `CHK("irq cleared", 1'b0, irq)
        gie <= 1'b0;
        tick(2);
        `CHK("bnd irq gie", 1'b0, adc_irq)
        gie <= 1'b1;
        bnd <= 1'b0;
        wr(ADDR_CTRL0, 32'h0000_0024);
        pd <= 1'b1;
        pulse_timer();
        `CHK("pd start", n0 + 5, n_start)
        pd <= 1'b0;
        tpd <= 1'b1;
        pulse_timer();
        `CHK("tpd start", n0 + 5, n_start)
        test_done();
    end
endmodule
`default_nettype wire
